/* logic/axrm_mem.sv */
`timescale 1ns/1ns
module axrm_mem
    import axrm_pkg::*;
#(
    parameter int DATA_W = AXRM_DATA_W_DEF
)
(
    // Clock
    input  wire logic                   ref_clk,
    // Fill port
    input  wire logic                   mem_wr_en,
    input  wire logic [AXRM_MEM_AW-1:0] mem_wr_index,
    input  wire logic [DATA_W-1:0]      mem_wr_data,
    // Read port
    input  wire logic [AXRM_MEM_AW-1:0] rd_index,
    output logic      [DATA_W-1:0]      rd_data
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // No reset on the array: contents are defined by the fill port only
    logic [DATA_W-1:0] word_reg [AXRM_MEM_DEPTH];

    always_ff @(posedge ref_clk)
    begin
        if (mem_wr_en)
        begin
            word_reg[mem_wr_index] <= mem_wr_data;
        end
    end

    assign rd_data = word_reg[rd_index];

endmodule : axrm_mem

/* logic/axrm_pkg.sv */
package axrm_pkg;

    // ------------------------------------------------------------
    // Bus field widths
    // ------------------------------------------------------------
    localparam int AXRM_ADDR_W   = 32;
    localparam int AXRM_LEN_W    = 8;
    localparam int AXRM_SIZE_W   = 3;
    localparam int AXRM_BURST_W  = 2;
    localparam int AXRM_RESP_W   = 2;
    localparam int AXRM_ID_W_MIN = 1;
    localparam int AXRM_ID_W_MAX = 16;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [AXRM_RESP_W-1:0]  AXRM_RESP_OKAY  = 2'h0;
    localparam logic [AXRM_BURST_W-1:0] AXRM_BURST_INCR = 2'h1;
    localparam logic [AXRM_BURST_W-1:0] AXRM_BURST_WRAP = 2'h2;

    // Build options
    localparam logic AXRM_MODE_PERIPH = 1'h0;
    localparam logic AXRM_MODE_MEMORY = 1'h1;

    // ------------------------------------------------------------
    // Defaults and reset values
    // ------------------------------------------------------------
    localparam int AXRM_DATA_W_DEF = 32;
    localparam int AXRM_MEM_AW     = 8;
    localparam int AXRM_MEM_DEPTH  = 256;

    localparam logic [AXRM_ADDR_W-1:0] AXRM_ADDR_RST = 32'h0000_0000;
    localparam logic [AXRM_ADDR_W-1:0] AXRM_ADDR_ONE = 32'h0000_0001;
    localparam logic [AXRM_LEN_W-1:0]  AXRM_LEN_ZERO = 8'h00;
    localparam logic [AXRM_LEN_W-1:0]  AXRM_LEN_ONE  = 8'h01;

    typedef enum logic [1:0]
    {
        AXRM_ST_IDLE  = 2'b01,
        AXRM_ST_BURST = 2'b10
    } axrm_state_e;

endpackage : axrm_pkg

/* logic/axrm_read_slave.sv */
`timescale 1ns/1ns
// Function
// RQ1 - Read address ID is used only in memory mode with ID support enabled
// RQ2 - Address ID and returned data ID widths range from 1 to 16 bits
// RQ3 - Start address taken once; later beat addresses derived from length, size, type
// RQ4 - Burst length field sets exactly how many beats are returned
// RQ5 - Master never asks for a beat size wider than the data bus
// RQ6 - Peripheral mode ignores size and treats every beat as full width
// RQ7 - Memory mode handles incrementing and wrapping bursts with matching addresses
// RQ8 - Peripheral mode ignores burst type and always increments
// RQ9 - Master holds address and control stable from valid until ready
// RQ10 - Address ready is high only when a new address can be taken
// RQ11 - Each data beat carries the ID of the request it answers
// RQ12 - Memory mode allows data widths 32, 64, 128 or 256 bits
// RQ13 - Peripheral mode allows data widths 8 through 256 bits
// RQ14 - Read response always reports OKAY
// RQ15 - Read response exists only in memory mode with ID support; the port is kept in every build here, always OKAY
// RQ16 - Read last marks the final beat only
// RQ17 - Read valid is high only while valid data is presented
// RQ18 - Master raises read ready when it can take data
// RQ19 - Beats returned equal burst length field plus one
// RQ20 - Transfers happen only when valid and ready are both high
module axrm_read_slave
    import axrm_pkg::*;
#(
    parameter logic MEM_MODE = AXRM_MODE_MEMORY,
    parameter logic ID_EN    = 1'h1,
    parameter int   ID_W     = 4,
    parameter int   DATA_W   = AXRM_DATA_W_DEF
)
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Read address channel
    input  wire logic [ID_W-1:0]         s_axi_arid,
    input  wire logic [AXRM_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [AXRM_LEN_W-1:0]   s_axi_arlen,
    input  wire logic [AXRM_SIZE_W-1:0]  s_axi_arsize,
    input  wire logic [AXRM_BURST_W-1:0] s_axi_arburst,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // Read data channel
    output logic      [ID_W-1:0]         s_axi_rid,
    output logic      [DATA_W-1:0]       s_axi_rdata,
    output logic      [AXRM_RESP_W-1:0]  s_axi_rresp,
    output logic                         s_axi_rlast,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Memory fill port
    input  wire logic                    mem_wr_en,
    input  wire logic [AXRM_MEM_AW-1:0]  mem_wr_index,
    input  wire logic [DATA_W-1:0]       mem_wr_data
);

    // ------------------------------------------------------------
    // Derived constants
    // ------------------------------------------------------------
    localparam int BYTE_SH = $clog2(DATA_W / 8);
    localparam logic [AXRM_SIZE_W-1:0] SIZE_FULL = AXRM_SIZE_W'(BYTE_SH);
    localparam logic ID_ON = MEM_MODE & ID_EN;
    localparam logic [ID_W-1:0] ID_ZERO = '0;
    localparam logic WIDTH_OK = (MEM_MODE == AXRM_MODE_MEMORY) ?           // see RQ12 RQ13
        (DATA_W == 32 || DATA_W == 64 || DATA_W == 128 || DATA_W == 256) :
        (DATA_W == 8 || DATA_W == 16 || DATA_W == 32 || DATA_W == 64 ||
         DATA_W == 128 || DATA_W == 256);

    // Byte address to memory word index, wrapping over the array
    function automatic logic [AXRM_MEM_AW-1:0] axrm_index(input logic [AXRM_ADDR_W-1:0] a);
        logic [AXRM_ADDR_W-1:0] w;
        w = a >> BYTE_SH;
        return w[AXRM_MEM_AW-1:0];
    endfunction : axrm_index

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    axrm_state_e              state_reg;
    axrm_state_e              state_next;
    logic [AXRM_ADDR_W-1:0]   addr_reg;
    logic [AXRM_LEN_W-1:0]    len_reg;
    logic [AXRM_SIZE_W-1:0]   size_reg;
    logic [AXRM_BURST_W-1:0]  burst_reg;
    logic [AXRM_LEN_W-1:0]    beat_reg;
    logic [ID_W-1:0]          rid_reg;
    logic [DATA_W-1:0]        rdata_reg;
    logic                     rlast_reg;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic                    ar_take;
    wire logic                    r_take;
    wire logic [AXRM_SIZE_W-1:0]  size_in;
    wire logic [AXRM_BURST_W-1:0] burst_in;
    wire logic [ID_W-1:0]         id_in;
    wire logic [AXRM_ADDR_W-1:0]  step;
    wire logic [AXRM_ADDR_W-1:0]  len_p1;
    wire logic [AXRM_ADDR_W-1:0]  wrap_mask;
    wire logic [AXRM_ADDR_W-1:0]  incr_addr;
    wire logic [AXRM_ADDR_W-1:0]  wrap_addr;
    wire logic [AXRM_ADDR_W-1:0]  addr_step;
    wire logic [AXRM_LEN_W-1:0]   beat_inc;
    wire logic [AXRM_MEM_AW-1:0]  rd_index;
    wire logic [DATA_W-1:0]       rd_data;

    assign ar_take  = s_axi_arvalid & s_axi_arready;                       // see RQ20
    assign r_take   = s_axi_rvalid & s_axi_rready;                         // see RQ20
    assign size_in  = MEM_MODE ? s_axi_arsize : SIZE_FULL;                 // see RQ6
    assign burst_in = MEM_MODE ? s_axi_arburst : AXRM_BURST_INCR;          // see RQ8
    assign id_in    = ID_ON ? s_axi_arid : ID_ZERO;                        // see RQ1

    // Later beats are aligned to the beat size, so an unaligned start
    // address only shifts the first beat
    assign step      = AXRM_ADDR_ONE << size_reg;                          // see RQ3
    assign len_p1    = {{(AXRM_ADDR_W-AXRM_LEN_W){1'b0}}, len_reg} + AXRM_ADDR_ONE;
    assign wrap_mask = (len_p1 << size_reg) - AXRM_ADDR_ONE;
    assign incr_addr = (addr_reg & ~(step - AXRM_ADDR_ONE)) + step;
    assign wrap_addr = (addr_reg & ~wrap_mask) | (incr_addr & wrap_mask);  // see RQ7
    assign addr_step = (burst_reg == AXRM_BURST_WRAP) ? wrap_addr : incr_addr;
    assign beat_inc  = beat_reg + AXRM_LEN_ONE;

    // One read port: the new burst's start or the next beat of the current one
    assign rd_index = axrm_index(ar_take ? s_axi_araddr : addr_step);

    // ------------------------------------------------------------
    // Memory
    // ------------------------------------------------------------
    axrm_mem #(
        .DATA_W (DATA_W)
    ) u_mem (
        .ref_clk      (ref_clk),
        .mem_wr_en    (mem_wr_en),
        .mem_wr_index (mem_wr_index),
        .mem_wr_data  (mem_wr_data),
        .rd_index     (rd_index),
        .rd_data      (rd_data)
    );

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            AXRM_ST_IDLE:
            begin
                if (ar_take)
                begin
                    state_next = AXRM_ST_BURST;
                end
            end
            AXRM_ST_BURST:
            begin
                if (r_take && rlast_reg)
                begin
                    state_next = AXRM_ST_IDLE;
                end
            end
            default:
            begin
                state_next = AXRM_ST_IDLE;
            end
        endcase
    end

    // One burst at a time: no new address until the last beat is gone
    assign s_axi_arready = (state_reg == AXRM_ST_IDLE);                    // see RQ10
    assign s_axi_rvalid  = (state_reg == AXRM_ST_BURST);                   // see RQ17
    // Response port kept in every build; it reads OKAY where it is not offered
    assign s_axi_rresp   = AXRM_RESP_OKAY;                                 // see RQ14 RQ15
    assign s_axi_rid     = rid_reg;                                        // see RQ11
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rlast   = rlast_reg;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= AXRM_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            addr_reg  <= AXRM_ADDR_RST;
            len_reg   <= AXRM_LEN_ZERO;
            size_reg  <= '0;
            burst_reg <= AXRM_BURST_INCR;
            beat_reg  <= AXRM_LEN_ZERO;
            rid_reg   <= ID_ZERO;
            rdata_reg <= '0;
            rlast_reg <= 1'b0;
        end
        else if (ar_take)
        begin
            addr_reg  <= s_axi_araddr;                                     // see RQ3
            len_reg   <= s_axi_arlen;                                      // see RQ4
            size_reg  <= size_in;
            burst_reg <= burst_in;
            beat_reg  <= AXRM_LEN_ZERO;
            rid_reg   <= id_in;                                            // see RQ11
            rdata_reg <= rd_data;
            rlast_reg <= (s_axi_arlen == AXRM_LEN_ZERO);                   // see RQ19
        end
        else if (r_take && !rlast_reg)
        begin
            addr_reg  <= addr_step;                                        // see RQ3
            beat_reg  <= beat_inc;
            rdata_reg <= rd_data;
            rlast_reg <= (beat_inc == len_reg);                            // see RQ16
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Independent count of accepted beats in the current burst
    logic [AXRM_LEN_W:0] hs_cnt_reg;
    logic [AXRM_LEN_W:0] len_ext;
    assign len_ext = {1'b0, len_reg};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || ar_take)
        begin
            hs_cnt_reg <= '0;
        end
        else if (r_take)
        begin
            hs_cnt_reg <= hs_cnt_reg + 1'b1;
        end
    end

    sequence seq_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence seq_last_beat;
        s_axi_rvalid && s_axi_rready && s_axi_rlast;
    endsequence

    sequence seq_stall;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    sequence seq_mid_beat;
        s_axi_rvalid && s_axi_rready && !s_axi_rlast;
    endsequence

    a_width_legal: assert property // see RQ12 RQ13
        (WIDTH_OK)
        else $error("data width outside the allowed set");
    a_id_width: assert property // see RQ2
        (ID_W >= AXRM_ID_W_MIN && ID_W <= AXRM_ID_W_MAX)
        else $error("ID width outside the allowed range");
    a_ar_ready_idle: assert property (s_axi_arready == !s_axi_rvalid) // see RQ10
        else $error("address ready high while a burst is in flight");
    a_ar_then_valid: assert property (seq_ar_take |=> s_axi_rvalid && !s_axi_arready) // see RQ17
        else $error("read valid did not follow an accepted address");
    a_rid_match: assert property // see RQ11
        (seq_ar_take |=> s_axi_rid == (ID_ON ? $past(s_axi_arid) : ID_ZERO))
        else $error("read ID does not match request ID");
    a_rid_off: assert property // see RQ1
        (!ID_ON && s_axi_rvalid |-> s_axi_rid == ID_ZERO)
        else $error("read ID not zero with ID support off");
    a_rid_hold: assert property // see RQ11
        (seq_mid_beat |=> $stable(s_axi_rid))
        else $error("read ID changed inside a burst");
    a_beat_count: assert property (seq_last_beat |-> hs_cnt_reg == len_ext) // see RQ4
        else $error("burst ended with wrong beat count");
    a_last_only: assert property // see RQ16
        (s_axi_rvalid && !s_axi_rlast |-> hs_cnt_reg < len_ext)
        else $error("last beat not flagged");
    a_single_beat: assert property // see RQ19
        (seq_ar_take ##0 (s_axi_arlen == AXRM_LEN_ZERO) |=> s_axi_rlast)
        else $error("single beat burst not marked last");
    a_hold_stall: assert property // see RQ20
        (seq_stall |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rlast))
        else $error("read beat changed while stalled");
    a_no_bubble: assert property // see RQ17
        (seq_mid_beat |=> s_axi_rvalid && !s_axi_arready)
        else $error("gap inside a burst");
    a_resp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == AXRM_RESP_OKAY) // see RQ14
        else $error("read response not OKAY");
    a_wrap_window: assert property // see RQ7
        (seq_mid_beat ##0 (burst_reg == AXRM_BURST_WRAP) |=>
         (addr_reg & ~wrap_mask) == ($past(addr_reg) & ~wrap_mask))
        else $error("wrap burst left its window");
    a_periph_incr: assert property // see RQ6 RQ8
        (!MEM_MODE && s_axi_rvalid |->
         burst_reg == AXRM_BURST_INCR && size_reg == SIZE_FULL)
        else $error("peripheral mode not full width incrementing");
    a_burst_exit: assert property (seq_last_beat |=> s_axi_arready && !s_axi_rvalid) // see RQ17
        else $error("burst did not end after last beat");

endmodule : axrm_read_slave

/* tb/axrm_mst_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------
// Read master model
// ------------------------------------------------
module axrm_mst_model
    import axrm_pkg::*;
#(
    parameter int ID_W   = 4,
    parameter int DATA_W = AXRM_DATA_W_DEF
)
(
    // Clock
    input  wire logic                    ref_clk,
    // Read address channel
    output logic      [ID_W-1:0]         arid,
    output logic      [AXRM_ADDR_W-1:0]  araddr,
    output logic      [AXRM_LEN_W-1:0]   arlen,
    output logic      [AXRM_SIZE_W-1:0]  arsize,
    output logic      [AXRM_BURST_W-1:0] arburst,
    output logic                         arvalid,
    input  wire logic                    arready,
    // Read data channel
    input  wire logic [ID_W-1:0]         rid,
    input  wire logic [DATA_W-1:0]       rdata,
    input  wire logic [AXRM_RESP_W-1:0]  rresp,
    input  wire logic                    rlast,
    input  wire logic                    rvalid,
    output logic                         rready
);
    logic [DATA_W-1:0]      q_data[$];
    logic [ID_W-1:0]        q_id[$];
    logic                   q_last[$];
    logic [AXRM_RESP_W-1:0] q_resp[$];
    int                     ar_busy_hi;

    initial
    begin
        {arid, araddr, arlen, arsize, arburst, arvalid, rready} = '0;
    end

    // Stall gives rready high one cycle in stall+1
    task read(input logic [ID_W-1:0] id, input logic [31:0] addr, input logic [7:0] len,
              input logic [2:0] size, input logic [1:0] burst, input int stall);
        int cyc;
        q_data.delete();
        q_id.delete();
        q_last.delete();
        q_resp.delete();
        ar_busy_hi = 0;
        cyc = 0;
        @(posedge ref_clk);
        #1;
        {arid, araddr, arlen, arsize, arburst} = {id, addr, len, size, burst};
        arvalid = 1'b1;
        @(posedge ref_clk);
        while (arready !== 1'b1 && cyc < 50)
        begin
            @(posedge ref_clk);
            cyc++;
        end
        #1;
        arvalid = 1'b0;
        // Released lines show the inverse so stale values cannot pass
        {arid, araddr, arlen, arsize, arburst} = ~{arid, araddr, arlen, arsize, arburst};
        cyc = 0;
        while (cyc < 600)
        begin
            #1;
            rready = (cyc % (stall + 1)) == stall;
            @(posedge ref_clk);
            if (arready !== 1'b0)
                ar_busy_hi++;
            if (rvalid === 1'b1 && rready)
            begin
                q_data.push_back(rdata);
                q_id.push_back(rid);
                q_last.push_back(rlast);
                q_resp.push_back(rresp);
                if (rlast === 1'b1)
                    break;
            end
            cyc++;
        end
        #1;
        rready = 1'b0;
    endtask : read
endmodule : axrm_mst_model

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
    import axrm_pkg::*;
    logic                    ref_clk, rst_n, arvalid, arready, rlast, rvalid, rready;
    logic                    mem_wr_en;
    logic [7:0]              mem_wr_index, arlen;
    logic [31:0]             mem_wr_data, araddr, rdata;
    logic [3:0]              arid, rid;
    logic [2:0]              arsize;
    logic [1:0]              arburst, rresp;
    int                      num_errors, checks;
    logic                    p_arready, p_rlast, p_rvalid;
    logic [3:0]              p_rid;
    logic [31:0]             p_rdata;
    logic [1:0]              p_rresp;
    logic [38:0]             p_q[$];

    // ------------------------------------------------
    // Clock, design and master
    // ------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    axrm_read_slave #(.MEM_MODE(AXRM_MODE_MEMORY), .ID_EN(1'h1), .ID_W(4), .DATA_W(32)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_arid(arid), .s_axi_araddr(araddr),
        .s_axi_arlen(arlen), .s_axi_arsize(arsize), .s_axi_arburst(arburst),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rid(rid),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rlast(rlast),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_wr_en(mem_wr_en),
        .mem_wr_index(mem_wr_index), .mem_wr_data(mem_wr_data));

    axrm_mst_model #(.ID_W(4), .DATA_W(32)) mst (
        .ref_clk(ref_clk), .arid(arid), .araddr(araddr), .arlen(arlen), .arsize(arsize),
        .arburst(arburst), .arvalid(arvalid), .arready(arready), .rid(rid),
        .rdata(rdata), .rresp(rresp), .rlast(rlast), .rvalid(rvalid), .rready(rready));

    // Peripheral build on the same bus: same timing, so it runs in step with dut
    axrm_read_slave #(.MEM_MODE(AXRM_MODE_PERIPH), .ID_EN(1'h0), .ID_W(4), .DATA_W(32)) dut_p (
        .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_arid(arid), .s_axi_araddr(araddr),
        .s_axi_arlen(arlen), .s_axi_arsize(arsize), .s_axi_arburst(arburst),
        .s_axi_arvalid(arvalid), .s_axi_arready(p_arready), .s_axi_rid(p_rid),
        .s_axi_rdata(p_rdata), .s_axi_rresp(p_rresp), .s_axi_rlast(p_rlast),
        .s_axi_rvalid(p_rvalid), .s_axi_rready(rready), .mem_wr_en(mem_wr_en),
        .mem_wr_index(mem_wr_index), .mem_wr_data(mem_wr_data));

    // Beats of the peripheral build, taken on the master's ready
    always @(posedge ref_clk)
    begin
        if (p_rvalid === 1'b1 && rready === 1'b1)
        begin
            p_q.push_back({p_rid, p_rresp, p_rlast, p_rdata});
        end
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [31:0] word(input logic [7:0] i);
        return {i, ~i, 8'h5a, i ^ 8'h3c};
    endfunction : word

    task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task wrap_up;
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // Expected beat addresses worked out from start, length, size and type
    task burst(input logic [3:0] id, input logic [31:0] addr, input logic [7:0] len,
               input logic [2:0] size, input logic [1:0] bt, input int stall);
        logic [31:0] a, al, wsz, base;
        logic [38:0] pexp;
        p_q.delete();
        mst.read(id, addr, len, size, bt, stall);
        chk("beats", mst.q_data.size(), len + 1);
        al = addr & ~((32'h1 << size) - 1);
        wsz = (len + 1) << size;
        base = addr & ~(wsz - 1);
        for (int n = 0; n <= len && n < mst.q_data.size(); n++)
        begin
            if (n == 0)
                a = addr;
            else if (bt == AXRM_BURST_WRAP)
                a = base + ((al - base + (n << size)) % wsz);
            else
                a = al + (n << size);
            chk("rdata", mst.q_data[n], word(a[9:2]));
            chk("rid", mst.q_id[n], id);
            chk("rlast", mst.q_last[n], n == len);
            chk("rresp", mst.q_resp[n], AXRM_RESP_OKAY);
        end
        chk("arready busy", mst.ar_busy_hi, 0);
        chk("rvalid idle", rvalid, 1'b0);
        chk("arready idle", arready, 1'b1);
        // Peripheral build ignores size, type and ID: full width increments, ID zero
        chk("periph beats", p_q.size(), len + 1);
        for (int n = 0; n <= len && n < p_q.size(); n++)
        begin
            pexp = {4'h0, AXRM_RESP_OKAY, n == len, word(8'(addr[9:2] + n))};
            chk("periph beat", p_q[n], pexp);
        end
        chk("periph idle", {p_arready, p_rvalid}, 2'b10);
    endtask : burst

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task t_reset;
        chk("arready rst", arready, 1'b1);
        chk("rvalid rst", rvalid, 1'b0);
        chk("rlast rst", rlast, 1'b0);
    endtask : t_reset

    // Back to back, fixed code taken as incrementing
    task t_incr;
        burst(4'h3, 32'h0000_0040, 8'h03, 3'h2, AXRM_BURST_INCR, 0);
        burst(4'h7, 32'h0000_0044, 8'h00, 3'h2, AXRM_BURST_INCR, 0);
        burst(4'h2, 32'h0000_0020, 8'h01, 3'h2, 2'h0, 3);
    endtask : t_incr

    task t_wrap;
        burst(4'ha, 32'h0000_0048, 8'h03, 3'h2, AXRM_BURST_WRAP, 2);
        burst(4'h5, 32'h0000_03f4, 8'h07, 3'h2, AXRM_BURST_WRAP, 1);
    endtask : t_wrap

    // Longest burst crossing the top of memory, then narrow unaligned beats
    task t_edge;
        burst(4'hf, 32'h0000_03fc, 8'hff, 3'h2, AXRM_BURST_INCR, 0);
        burst(4'h1, 32'h0000_0011, 8'h03, 3'h1, AXRM_BURST_INCR, 1);
    endtask : t_edge

    initial
    begin
        {rst_n, mem_wr_en, mem_wr_index, mem_wr_data, num_errors, checks} = '0;
        repeat (3) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        for (int i = 0; i < 256; i++)
        begin
            {mem_wr_en, mem_wr_index, mem_wr_data} = {1'b1, 8'(i), word(8'(i))};
            @(posedge ref_clk);
            #1;
        end
        mem_wr_en = 1'b0;
        t_incr();
        t_wrap();
        t_edge();
        wrap_up();
    end

    initial
    begin
        #50000;
        num_errors++;
        wrap_up();
    end
endmodule : tb
